// [hdl/irq_cpu_if_map.svh]
// Encodings, field positions, reset values and fixed codes of the register bank
`ifndef IRQ_CPU_IF_MAP_SVH
`define IRQ_CPU_IF_MAP_SVH

// Common instruction encoding of every register here
`define IRQIF_OP0           2'h3
`define IRQIF_CRN           4'hc

// Register-enable registers, one per privilege level
`define IRQIF_SRE1_OP1      3'h0
`define IRQIF_SRE2_OP1      3'h4
`define IRQIF_SRE3_OP1      3'h6
`define IRQIF_SRE_CRM       4'hc
`define IRQIF_SRE_OP2       3'h5

// Virtual interface registers
`define IRQIF_VIRT_OP1      3'h0
`define IRQIF_VAP0_CRM      4'h8
`define IRQIF_VAP0_OP2      3'h4
`define IRQIF_VAP1_CRM      4'h9
`define IRQIF_VAP1_OP2      3'h0
`define IRQIF_VBP0_CRM      4'h8
`define IRQIF_VBP0_OP2      3'h3
`define IRQIF_VBP1_CRM      4'hc
`define IRQIF_VBP1_OP2      3'h3
`define IRQIF_VCTL_CRM      4'hc
`define IRQIF_VCTL_OP2      3'h4

// Least privilege level for each register family
`define IRQIF_LVL_SRE1      2'h1
`define IRQIF_LVL_SRE2      2'h2
`define IRQIF_LVL_SRE3      2'h3
`define IRQIF_LVL_VIRT      2'h1

// Register-enable field positions
`define IRQIF_SRE_SELECT    0
`define IRQIF_SRE_FASTBYP   1
`define IRQIF_SRE_IRQBYP    2
`define IRQIF_SRE_LOWER     3

// Virtual control field positions and fixed codes
`define IRQIF_VCTL_CBPR     0
`define IRQIF_VCTL_EOIMODE  1
`define IRQIF_VCTL_PRIW_LSB 8
`define IRQIF_VCTL_IDW_LSB  11
`define IRQIF_VCTL_SYSTEM_ERROR_IRQ_SUPPORT     14
`define IRQIF_VCTL_A3V      15
`define IRQIF_PRIW_CODE     3'h4
`define IRQIF_IDW_CODE      3'h0
`define IRQIF_VCTL_ID_FIELD 8'h84

// Split-point limits and reset values
`define IRQIF_BP_W          3
`define IRQIF_BP0_MIN       3'h2
`define IRQIF_BP1_MIN_SEC   3'h2
`define IRQIF_BP1_MIN_NS    3'h3
`define IRQIF_BP_MAX        3'h7

// Active-priority layout
`define IRQIF_AP_RESET      32'h00000000
`define IRQIF_PRIO_SHIFT    3

`endif

// [hdl/irq_cpu_if_pkg.sv]
// Types shared by the system-register bank, its pipeline model and its bench
package irq_cpu_if_pkg;

  // One system-register instruction from the pipeline
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  op0;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    logic [1:0]  level;
    logic        secure;
    logic [31:0] wdata;
  } sysreg_req_t;

  // Answer to one instruction
  typedef struct packed {
    logic        ack;
    logic        undef;
    logic [31:0] rdata;
  } sysreg_rsp_t;

  // Preemption query for a new virtual interrupt
  typedef struct packed {
    logic       valid;
    logic       group1;
    logic       secure;
    logic [7:0] prio;
  } preempt_req_t;

  // Register selected by an instruction
  typedef enum {
    SEL_NONE,
    SEL_SRE1,
    SEL_SRE2,
    SEL_SRE3,
    SEL_VAP0,
    SEL_VAP1,
    SEL_VBP0,
    SEL_VBP1,
    SEL_VCTL
  } reg_sel_t;

endpackage

// [hdl/irq_preempt_check.sv]
// Group-priority preemption test against the running priority
`timescale 1ns/1ns
`include "irq_cpu_if_map.svh"
module irq_preempt_check #(
  parameter int LEVELS = 32
) (
  // Active priorities of both groups
  input  wire logic [LEVELS-1:0] activeBits,
  // Split point and its interpretation
  input  wire logic [2:0]        splitPoint,
  input  wire logic              fieldFromPoint,
  // Candidate and verdict
  input  wire logic [7:0]        candPrio,
  output      logic              mayPreempt
);

  logic [7:0] runPrio;    // Priority of the highest active level
  logic       anyActive;  // Some level is active
  logic [3:0] shift;      // Width of the subpriority part
  logic [7:0] groupMask;  // Group-priority bits kept

  // Lowest set bit is the running priority, step of eight
  always_comb begin
    runPrio   = 8'hff;
    anyActive = 1'b0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (activeBits[i]) begin
        runPrio   = 8'(i << `IRQIF_PRIO_SHIFT);
        anyActive = 1'b1;
      end
    end
  end

  // Only the group part decides preemption
  always_comb begin
    shift      = fieldFromPoint ? {1'b0, splitPoint} : ({1'b0, splitPoint} + 4'h1);
    groupMask  = 8'(8'hff << shift);
    mayPreempt = !anyActive || ((candPrio & groupMask) < (runPrio & groupMask));
  end

endmodule // irq_preempt_check

// [hdl/irq_cpu_if_sysreg_bank.sv]
// Register-enable and virtual interface register bank of the interrupt CPU interface
`timescale 1ns/1ns
`include "irq_cpu_if_map.svh"
module irq_cpu_if_sysreg_bank #(
  parameter int LEVELS = 32
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // System-register instruction port
  input  wire irq_cpu_if_pkg::sysreg_req_t   sysReq,
  output      irq_cpu_if_pkg::sysreg_rsp_t   sysRsp,
  // Preemption query
  input  wire irq_cpu_if_pkg::preempt_req_t  preemptReq,
  output      logic                          preemptDone,
  output      logic                          mayPreempt,
  // Control levels toward the core
  output      logic                          irqBypassDisable,
  output      logic                          fastIrqBypassDisable,
  output      logic                          virtualEndOfIrqMode,
  output      logic                          virtualCommonSplitPoint
);

  irq_cpu_if_pkg::reg_sel_t regSel;               // Encoding match
  irq_cpu_if_pkg::reg_sel_t accessSel;            // Match that passes the level check
  logic [1:0]               minLevel;             // Least level for the match
  logic                     wrEn;                 // Write of a decoded register
  logic [LEVELS-1:0]        activePrio [2];       // Active bitmaps, index is the group
  logic [2:0]               splitPoint0;          // Group-0 split point
  logic [2:0]               splitPoint1 [2];      // Group-1 split point, index is secure
  logic [31:0]              readData;             // Read value of the access
  logic [2:0]               effPoint;             // Split point for the query
  logic                     effFromPoint;         // Group-1 field taken from the point
  logic                     next_mayPreempt;      // Verdict of the check

  // Full encoding compare, used for every register
  function automatic logic encMatch(input irq_cpu_if_pkg::sysreg_req_t r,
                                    input logic [2:0] op1,
                                    input logic [3:0] crm,
                                    input logic [2:0] op2);
    return r.op0 == `IRQIF_OP0 && r.crn == `IRQIF_CRN &&
           r.op1 == op1 && r.crm == crm && r.op2 == op2;
  endfunction

  // Split point plus one, held at seven
  function automatic logic [2:0] satPlusOne(input logic [2:0] bp);
    return (bp == `IRQIF_BP_MAX) ? `IRQIF_BP_MAX : 3'(bp + 3'h1);
  endfunction

  // Clamp a written split point to its least value
  function automatic logic [2:0] clampPoint(input logic [2:0] bp, input logic [2:0] least);
    return (bp < least) ? least : bp;
  endfunction

  // Instruction decode and level check
  always_comb begin
    regSel   = irq_cpu_if_pkg::SEL_NONE;
    minLevel = `IRQIF_LVL_VIRT;
    if (encMatch(sysReq, `IRQIF_SRE1_OP1, `IRQIF_SRE_CRM, `IRQIF_SRE_OP2)) begin
      regSel   = irq_cpu_if_pkg::SEL_SRE1;
      minLevel = `IRQIF_LVL_SRE1;
    end else if (encMatch(sysReq, `IRQIF_SRE2_OP1, `IRQIF_SRE_CRM, `IRQIF_SRE_OP2)) begin
      regSel   = irq_cpu_if_pkg::SEL_SRE2;
      minLevel = `IRQIF_LVL_SRE2;
    end else if (encMatch(sysReq, `IRQIF_SRE3_OP1, `IRQIF_SRE_CRM, `IRQIF_SRE_OP2)) begin
      regSel   = irq_cpu_if_pkg::SEL_SRE3;
      minLevel = `IRQIF_LVL_SRE3;
    end else if (encMatch(sysReq, `IRQIF_VIRT_OP1, `IRQIF_VAP0_CRM, `IRQIF_VAP0_OP2)) begin
      regSel = irq_cpu_if_pkg::SEL_VAP0;
    end else if (encMatch(sysReq, `IRQIF_VIRT_OP1, `IRQIF_VAP1_CRM, `IRQIF_VAP1_OP2)) begin
      regSel = irq_cpu_if_pkg::SEL_VAP1;
    end else if (encMatch(sysReq, `IRQIF_VIRT_OP1, `IRQIF_VBP0_CRM, `IRQIF_VBP0_OP2)) begin
      regSel = irq_cpu_if_pkg::SEL_VBP0;
    end else if (encMatch(sysReq, `IRQIF_VIRT_OP1, `IRQIF_VBP1_CRM, `IRQIF_VBP1_OP2)) begin
      regSel = irq_cpu_if_pkg::SEL_VBP1;
    end else if (encMatch(sysReq, `IRQIF_VIRT_OP1, `IRQIF_VCTL_CRM, `IRQIF_VCTL_OP2)) begin
      regSel = irq_cpu_if_pkg::SEL_VCTL;
    end
    // Too low a level sees nothing
    accessSel = (sysReq.level >= minLevel) ? regSel : irq_cpu_if_pkg::SEL_NONE;
    wrEn      = sysReq.valid && sysReq.write && (accessSel != irq_cpu_if_pkg::SEL_NONE);
  end

  // Single copy of both bypass disables behind all three levels
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqBypassDisable     <= 1'b0;
      fastIrqBypassDisable <= 1'b0;
    end else if (wrEn && (accessSel == irq_cpu_if_pkg::SEL_SRE1 ||
                          accessSel == irq_cpu_if_pkg::SEL_SRE2 ||
                          accessSel == irq_cpu_if_pkg::SEL_SRE3)) begin
      irqBypassDisable     <= sysReq.wdata[`IRQIF_SRE_IRQBYP];
      fastIrqBypassDisable <= sysReq.wdata[`IRQIF_SRE_FASTBYP];
    end
  end

  // Virtual control: end-of-interrupt mode and common split point
  always_ff @(posedge mclk) begin
    if (reset) begin
      virtualEndOfIrqMode     <= 1'b0;
      virtualCommonSplitPoint <= 1'b0;
    end else if (wrEn && accessSel == irq_cpu_if_pkg::SEL_VCTL) begin
      virtualEndOfIrqMode     <= sysReq.wdata[`IRQIF_VCTL_EOIMODE];
      virtualCommonSplitPoint <= sysReq.wdata[`IRQIF_VCTL_CBPR];
    end
  end

  // Group-0 split point, never below its least value
  always_ff @(posedge mclk) begin
    if (reset) begin
      splitPoint0 <= `IRQIF_BP0_MIN;
    end else if (wrEn && accessSel == irq_cpu_if_pkg::SEL_VBP0) begin
      splitPoint0 <= clampPoint(sysReq.wdata[2:0], `IRQIF_BP0_MIN);
    end
  end

  // Group-1 split point, one copy per security state
  always_ff @(posedge mclk) begin
    if (reset) begin
      splitPoint1[0] <= `IRQIF_BP1_MIN_NS;
      splitPoint1[1] <= `IRQIF_BP1_MIN_SEC;
    end else if (wrEn && accessSel == irq_cpu_if_pkg::SEL_VBP1 && !virtualCommonSplitPoint) begin
      if (sysReq.secure) begin
        splitPoint1[1] <= clampPoint(sysReq.wdata[2:0], `IRQIF_BP1_MIN_SEC);
      end else begin
        splitPoint1[0] <= clampPoint(sysReq.wdata[2:0], `IRQIF_BP1_MIN_NS);
      end
    end
  end

  // Active-priority bitmaps, one per group
  for (genvar g = 0; g < 2; g++) begin : gActive
    always_ff @(posedge mclk) begin
      if (reset) begin
        activePrio[g] <= LEVELS'(`IRQIF_AP_RESET);
      end else if (wrEn && accessSel == ((g == 0) ? irq_cpu_if_pkg::SEL_VAP0
                                                  : irq_cpu_if_pkg::SEL_VAP1)) begin
        activePrio[g] <= sysReq.wdata[LEVELS-1:0];
      end
    end
  end

  // Read value of the addressed register
  always_comb begin
    readData = 32'h00000000;  // Reserved bits stay zero
    unique case (accessSel)
      irq_cpu_if_pkg::SEL_SRE1: begin
        readData[`IRQIF_SRE_SELECT]  = 1'b1;
        readData[`IRQIF_SRE_FASTBYP] = fastIrqBypassDisable;
        readData[`IRQIF_SRE_IRQBYP]  = irqBypassDisable;
      end
      irq_cpu_if_pkg::SEL_SRE2, irq_cpu_if_pkg::SEL_SRE3: begin
        readData[`IRQIF_SRE_SELECT]  = 1'b1;
        readData[`IRQIF_SRE_FASTBYP] = fastIrqBypassDisable;
        readData[`IRQIF_SRE_IRQBYP]  = irqBypassDisable;
        readData[`IRQIF_SRE_LOWER]   = 1'b1;
      end
      irq_cpu_if_pkg::SEL_VAP0: readData[LEVELS-1:0] = activePrio[0];
      irq_cpu_if_pkg::SEL_VAP1: readData[LEVELS-1:0] = activePrio[1];
      irq_cpu_if_pkg::SEL_VBP0: readData[2:0] = splitPoint0;
      irq_cpu_if_pkg::SEL_VBP1: begin
        // Common mode shows group-0 point plus one
        readData[2:0] = virtualCommonSplitPoint ? satPlusOne(splitPoint0)
                                                : splitPoint1[sysReq.secure];
      end
      irq_cpu_if_pkg::SEL_VCTL: begin
        readData[`IRQIF_VCTL_A3V]                          = 1'b1;
        readData[`IRQIF_VCTL_SYSTEM_ERROR_IRQ_SUPPORT]                         = 1'b0;
        readData[`IRQIF_VCTL_IDW_LSB+2:`IRQIF_VCTL_IDW_LSB]   = `IRQIF_IDW_CODE;
        readData[`IRQIF_VCTL_PRIW_LSB+2:`IRQIF_VCTL_PRIW_LSB] = `IRQIF_PRIW_CODE;
        readData[`IRQIF_VCTL_EOIMODE]                      = virtualEndOfIrqMode;
        readData[`IRQIF_VCTL_CBPR]                         = virtualCommonSplitPoint;
      end
      irq_cpu_if_pkg::SEL_NONE: readData = 32'h00000000;
    endcase
  end

  // Answer one cycle after each instruction
  always_ff @(posedge mclk) begin
    if (reset) begin
      sysRsp <= '0;
    end else begin
      sysRsp.ack   <= sysReq.valid;
      sysRsp.undef <= sysReq.valid && (accessSel == irq_cpu_if_pkg::SEL_NONE);
      sysRsp.rdata <= (sysReq.valid && !sysReq.write) ? readData : 32'h00000000;
    end
  end

  // Split point governing the queried group
  always_comb begin
    if (preemptReq.group1 && !virtualCommonSplitPoint) begin
      effPoint     = splitPoint1[preemptReq.secure];
      effFromPoint = 1'b1;
    end else begin
      effPoint     = splitPoint0;
      effFromPoint = 1'b0;
    end
  end

  // Group-priority comparison
  irq_preempt_check #(
    .LEVELS         (LEVELS)
  ) uCheck (
    .activeBits     (activePrio[0] | activePrio[1]),
    .splitPoint     (effPoint),
    .fieldFromPoint (effFromPoint),
    .candPrio       (preemptReq.prio),
    .mayPreempt     (next_mayPreempt)
  );

  // Registered verdict, one cycle after the query
  always_ff @(posedge mclk) begin
    if (reset) begin
      preemptDone <= 1'b0;
      mayPreempt  <= 1'b0;
    end else begin
      preemptDone <= preemptReq.valid;
      mayPreempt  <= preemptReq.valid && next_mayPreempt;
    end
  end

  // Checks on the bank
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic rdSre;   // Read of any enable register
  logic rdVctl;  // Read of the virtual control
  assign rdSre  = sysReq.valid && !sysReq.write && (accessSel == irq_cpu_if_pkg::SEL_SRE1 ||
                  accessSel == irq_cpu_if_pkg::SEL_SRE2 || accessSel == irq_cpu_if_pkg::SEL_SRE3);
  assign rdVctl = sysReq.valid && !sysReq.write && accessSel == irq_cpu_if_pkg::SEL_VCTL;

  a_sre_reads_one: assert property (rdSre |=> sysRsp.rdata[0] && sysRsp.rdata[31:4] == 28'h0)
    else $error("enable register bit 0 not one");
  a_bypass_irq_alias: assert property (wrEn && accessSel == irq_cpu_if_pkg::SEL_SRE1
      |=> irqBypassDisable == $past(sysReq.wdata[2]))
    else $error("level-1 write missed irq bypass copy");
  a_bypass_fast_alias: assert property (wrEn && accessSel == irq_cpu_if_pkg::SEL_SRE2
      |=> fastIrqBypassDisable == $past(sysReq.wdata[1]))
    else $error("level-2 write missed fast bypass copy");
  a_shared_bypass: assert property (rdSre |=> sysRsp.rdata[2:1] == {irqBypassDisable, fastIrqBypassDisable})
    else $error("enable register bypass bits not shared");
  a_lower_enable: assert property (sysReq.valid && !sysReq.write && accessSel == irq_cpu_if_pkg::SEL_SRE3
      |=> sysRsp.rdata[3])
    else $error("level-3 lower enable not one");
  a_lower_enable2: assert property (sysReq.valid && !sysReq.write && accessSel == irq_cpu_if_pkg::SEL_SRE2
      |=> sysRsp.rdata[3])
    else $error("level-2 lower enable not one");
  a_ap_reset: assert property ($fell(reset) |-> activePrio[0] == '0 && activePrio[1] == '0)
    else $error("active priorities not cleared by reset");
  a_ap_write: assert property (wrEn && accessSel == irq_cpu_if_pkg::SEL_VAP1
      |=> activePrio[1] == $past(sysReq.wdata[LEVELS-1:0]))
    else $error("active priority write lost");
  a_ctl_ident: assert property (rdVctl |=> sysRsp.rdata[15:8] == `IRQIF_VCTL_ID_FIELD)
    else $error("control identification field wrong");
  a_ctl_reserved: assert property (rdVctl |=> sysRsp.rdata[31:16] == 16'h0 && sysRsp.rdata[7:2] == 6'h0)
    else $error("control reserved bits not zero");
  a_bp_minimum: assert property (splitPoint0 >= 3'h2 && splitPoint1[0] >= 3'h3 && splitPoint1[1] >= 3'h2)
    else $error("split point below least value");
  a_common_read: assert property (sysReq.valid && !sysReq.write && accessSel == irq_cpu_if_pkg::SEL_VBP1
      && virtualCommonSplitPoint |=> sysRsp.rdata[2:0] == satPlusOne($past(splitPoint0)))
    else $error("common split read wrong");
  a_eoi_mode: assert property (wrEn && accessSel == irq_cpu_if_pkg::SEL_VCTL
      |=> virtualEndOfIrqMode == $past(sysReq.wdata[1]))
    else $error("end-of-interrupt mode not stored");
  a_bad_encoding: assert property (sysReq.valid && sysReq.op0 != 2'h3 |=> sysRsp.ack && sysRsp.undef)
    else $error("foreign encoding not refused");
  a_idle_preempts: assert property (preemptReq.valid && activePrio[0] == '0 && activePrio[1] == '0
      |=> mayPreempt && preemptDone)
    else $error("idle interface refused preemption");

endmodule // irq_cpu_if_sysreg_bank

// [tb/core_pipe_model.sv]
// Pipeline model that issues system-register instructions to the bank
`timescale 1ns/1ns
`include "irq_cpu_if_map.svh"
module core_pipe_model (
  // Clock
  input  wire logic                         mclk,
  // Instruction port toward the bank
  output      irq_cpu_if_pkg::sysreg_req_t  sysReq,
  input  wire irq_cpu_if_pkg::sysreg_rsp_t  sysRsp
);
  // Idle until the first instruction
  initial sysReq = '0;

  // One instruction for one cycle, then the answer one edge later
  task automatic issue(input logic wr, input logic [11:0] enc, input logic [1:0] lvl, input logic sec,
                       input logic [31:0] wd, output logic [31:0] rd, output logic und, output logic ok);
    @(negedge mclk);
    sysReq.valid  = 1'b1;
    sysReq.write  = wr;
    sysReq.crn    = `IRQIF_CRN;
    {sysReq.op0, sysReq.op1, sysReq.crm, sysReq.op2} = enc;
    sysReq.level  = lvl;
    sysReq.secure = sec;
    sysReq.wdata  = wd;
    // Taken at the next rising edge; the answer stands until the edge after
    @(negedge mclk);
    ok  = sysRsp.ack;
    und = sysRsp.undef;
    rd  = sysRsp.rdata;
    // Released lines show the inverse so a stale value never passes
    sysReq.valid = 1'b0;
    sysReq.wdata = ~wd;
    sysReq.write = ~wr;
  endtask
endmodule // core_pipe_model

// [tb/irq_cpu_if_sysreg_bank_tb.sv]
// Self-checking bench of the system-register bank
`timescale 1ns/1ns
`include "irq_cpu_if_map.svh"
module irq_cpu_if_sysreg_bank_tb;
  // One table row: an access and its expected answer
  typedef struct packed {
    logic        wr;
    logic [3:0]  r;
    logic [1:0]  lvl;
    logic        sec;
    logic [31:0] wd;
    logic [31:0] ex;
    logic        un;
  } row_t;

  logic                         mclk;         // Core clock
  logic                         reset;        // Synchronous reset
  irq_cpu_if_pkg::sysreg_req_t  sysReq;       // Instruction from the model
  irq_cpu_if_pkg::sysreg_rsp_t  sysRsp;       // Answer from the bank
  irq_cpu_if_pkg::preempt_req_t preemptReq;   // Preemption query
  logic                         preemptDone;  // Query answered
  logic                         mayPreempt;   // Query verdict
  logic                         irqByp;       // Normal bypass disable
  logic                         fastByp;      // Fast bypass disable
  logic                         eoiMode;      // End-of-interrupt mode
  logic                         commonSplit;  // Common split point
  int                           nFail;        // Mismatches
  int                           cmpCount;     // Comparisons
  logic [31:0]                  rd;           // Read data seen
  logic                         un;           // Refusal seen
  // Codes: 0..2 enable regs, 3/4 active, 5/6 split, 7 control, 8 unmapped
  row_t rows [33] = '{
    {1'b0,4'h7,2'h1,1'b0,32'h0,32'h8400,1'b0}, {1'b0,4'h0,2'h1,1'b0,32'h0,32'h1,1'b0},
    {1'b0,4'h1,2'h2,1'b0,32'h0,32'h9,1'b0}, {1'b0,4'h2,2'h3,1'b0,32'h0,32'h9,1'b0},
    {1'b0,4'h3,2'h1,1'b0,32'h0,32'h0,1'b0}, {1'b0,4'h4,2'h1,1'b0,32'h0,32'h0,1'b0},
    {1'b0,4'h5,2'h1,1'b0,32'h0,32'h2,1'b0}, {1'b0,4'h6,2'h1,1'b0,32'h0,32'h3,1'b0},
    {1'b0,4'h6,2'h1,1'b1,32'h0,32'h2,1'b0}, {1'b1,4'h2,2'h3,1'b0,32'hffffffff,32'h0,1'b0},
    {1'b0,4'h0,2'h1,1'b0,32'h0,32'h7,1'b0}, {1'b0,4'h1,2'h2,1'b0,32'h0,32'hf,1'b0},
    {1'b1,4'h0,2'h1,1'b0,32'h0,32'h0,1'b0}, {1'b0,4'h2,2'h3,1'b0,32'h0,32'h9,1'b0},
    {1'b1,4'h4,2'h1,1'b0,32'h80000000,32'h0,1'b0}, {1'b0,4'h4,2'h1,1'b0,32'h0,32'h80000000,1'b0},
    {1'b1,4'h5,2'h1,1'b0,32'h0,32'h0,1'b0}, {1'b0,4'h5,2'h1,1'b0,32'h0,32'h2,1'b0},
    {1'b1,4'h6,2'h1,1'b0,32'h0,32'h0,1'b0}, {1'b0,4'h6,2'h1,1'b0,32'h0,32'h3,1'b0},
    {1'b1,4'h7,2'h1,1'b0,32'hffffffff,32'h0,1'b0}, {1'b0,4'h7,2'h1,1'b0,32'h0,32'h8403,1'b0},
    {1'b0,4'h6,2'h1,1'b0,32'h0,32'h3,1'b0}, {1'b1,4'h5,2'h1,1'b0,32'h7,32'h0,1'b0},
    {1'b0,4'h6,2'h1,1'b1,32'h0,32'h7,1'b0}, {1'b1,4'h6,2'h1,1'b0,32'h5,32'h0,1'b0},
    {1'b1,4'h7,2'h1,1'b0,32'h0,32'h0,1'b0}, {1'b0,4'h6,2'h1,1'b0,32'h0,32'h3,1'b0},
    {1'b0,4'h2,2'h2,1'b0,32'h0,32'h0,1'b1}, {1'b0,4'h8,2'h3,1'b0,32'h0,32'h0,1'b1},
    {1'b1,4'h3,2'h0,1'b0,32'hffffffff,32'h0,1'b1}, {1'b0,4'h3,2'h1,1'b0,32'h0,32'h0,1'b0},
    {1'b0,4'h1,2'h1,1'b0,32'h0,32'h0,1'b1}};

  // Bank under test
  irq_cpu_if_sysreg_bank #(.LEVELS(32)) i_dut (
    .mclk(mclk), .reset(reset), .sysReq(sysReq), .sysRsp(sysRsp),
    .preemptReq(preemptReq), .preemptDone(preemptDone), .mayPreempt(mayPreempt),
    .irqBypassDisable(irqByp), .fastIrqBypassDisable(fastByp),
    .virtualEndOfIrqMode(eoiMode), .virtualCommonSplitPoint(commonSplit));

  // Pipeline partner
  core_pipe_model i_core (.mclk(mclk), .sysReq(sysReq), .sysRsp(sysRsp));

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Encoding of each register code
  function automatic logic [11:0] enc(input logic [3:0] r);
    case (r)
      4'h0: enc = {`IRQIF_OP0, `IRQIF_SRE1_OP1, `IRQIF_SRE_CRM, `IRQIF_SRE_OP2};
      4'h1: enc = {`IRQIF_OP0, `IRQIF_SRE2_OP1, `IRQIF_SRE_CRM, `IRQIF_SRE_OP2};
      4'h2: enc = {`IRQIF_OP0, `IRQIF_SRE3_OP1, `IRQIF_SRE_CRM, `IRQIF_SRE_OP2};
      4'h3: enc = {`IRQIF_OP0, `IRQIF_VIRT_OP1, `IRQIF_VAP0_CRM, `IRQIF_VAP0_OP2};
      4'h4: enc = {`IRQIF_OP0, `IRQIF_VIRT_OP1, `IRQIF_VAP1_CRM, `IRQIF_VAP1_OP2};
      4'h5: enc = {`IRQIF_OP0, `IRQIF_VIRT_OP1, `IRQIF_VBP0_CRM, `IRQIF_VBP0_OP2};
      4'h6: enc = {`IRQIF_OP0, `IRQIF_VIRT_OP1, `IRQIF_VBP1_CRM, `IRQIF_VBP1_OP2};
      4'h7: enc = {`IRQIF_OP0, `IRQIF_VIRT_OP1, `IRQIF_VCTL_CRM, `IRQIF_VCTL_OP2};
      // Foreign op0 as well as an unmapped register
      default: enc = 12'h000;
    endcase
  endfunction

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One register access through the partner
  task automatic acc(input logic [3:0] r, input logic wr, input logic [1:0] lvl, input logic sec,
                     input logic [31:0] wd, output logic [31:0] d, output logic u);
    logic ok;
    i_core.issue(wr, enc(r), lvl, sec, wd, d, u, ok);
    check({31'h0, ok}, 32'h1, "no acknowledge");
  endtask

  // One preemption query and its verdict
  task automatic pre(input logic g1, input logic [7:0] p, input logic ex);
    @(negedge mclk);
    preemptReq = {1'b1, g1, 1'b0, p};
    // Verdict stands for the cycle after the query is taken
    @(negedge mclk);
    check({30'h0, preemptDone, mayPreempt}, {30'h0, 1'b1, ex}, "preempt verdict");
    preemptReq = {1'b0, ~g1, 1'b1, ~p};
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    nFail++;
    print_verdict();
  end

  // Main sequence
  initial begin
    nFail = 0;
    cmpCount = 0;
    reset = 1'b1;
    preemptReq = '0;
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    // Table of register accesses
    foreach (rows[i]) begin
      acc(rows[i].r, rows[i].wr, rows[i].lvl, rows[i].sec, rows[i].wd, rd, un);
      check(rd, rows[i].ex, "row data");
      check({31'h0, un}, {31'h0, rows[i].un}, "row refusal");
    end
    $display("test register table done");
    // Bypass and mode levels
    acc(4'h1, 1'b1, 2'h2, 1'b0, 32'h6, rd, un);
    check({28'h0, irqByp, fastByp, eoiMode, commonSplit}, 32'hc, "both bypass off");
    acc(4'h2, 1'b1, 2'h3, 1'b0, 32'h4, rd, un);
    check({28'h0, irqByp, fastByp, eoiMode, commonSplit}, 32'h8, "normal bypass off");
    acc(4'h7, 1'b1, 2'h1, 1'b0, 32'h2, rd, un);
    check({28'h0, irqByp, fastByp, eoiMode, commonSplit}, 32'ha, "eoi mode");
    acc(4'h7, 1'b1, 2'h1, 1'b0, 32'h1, rd, un);
    check({28'h0, irqByp, fastByp, eoiMode, commonSplit}, 32'h9, "common split");
    acc(4'h0, 1'b1, 2'h1, 1'b0, 32'h2, rd, un);
    check({28'h0, irqByp, fastByp, eoiMode, commonSplit}, 32'h5, "fast bypass off");
    $display("test control levels done");
    // Preemption against priority 0x10 held in group 0
    acc(4'h7, 1'b1, 2'h1, 1'b0, 32'h0, rd, un);
    acc(4'h3, 1'b1, 2'h1, 1'b0, 32'h4, rd, un);
    acc(4'h4, 1'b1, 2'h1, 1'b0, 32'h0, rd, un);
    acc(4'h5, 1'b1, 2'h1, 1'b0, 32'h2, rd, un);
    pre(1'b0, 8'h08, 1'b1);
    pre(1'b0, 8'h10, 1'b0);
    pre(1'b0, 8'h0c, 1'b1);
    acc(4'h5, 1'b1, 2'h1, 1'b0, 32'h4, rd, un);
    pre(1'b0, 8'h08, 1'b0);
    pre(1'b1, 8'h08, 1'b1);
    $display("test preemption done");
    // Reset in mid-run
    @(negedge mclk);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    check({28'h0, irqByp, fastByp, eoiMode, commonSplit}, 32'h0, "levels in reset");
    reset = 1'b0;
    acc(4'h3, 1'b0, 2'h1, 1'b0, 32'h0, rd, un);
    check(rd, 32'h0, "active after reset");
    acc(4'h6, 1'b0, 2'h1, 1'b0, 32'h0, rd, un);
    check(rd, 32'h3, "split after reset");
    pre(1'b0, 8'hf8, 1'b1);
    $display("test reset done");
    print_verdict();
  end
endmodule // irq_cpu_if_sysreg_bank_tb
